// File: pkg/cbf_defs.svh
// register indices, field positions, reset values and timing constants
`ifndef CBF_DEFS_SVH
`define CBF_DEFS_SVH
// register indices; byte address is four times the index
`define CBF_IDX_MASK    8'h10
`define CBF_IDX_BCFG    8'h11
`define CBF_IDX_DCFG    8'h12
`define CBF_IDX_TCFG    8'h13
`define CBF_IDX_DFLT    8'h14
`define CBF_IDX_GFLT    8'h15
`define CBF_IDX_SHDN    8'h16
`define CBF_IDX_ISTAT   8'h17
`define CBF_IDX_IMASK   8'h18
`define CBF_IDX_GDIR    8'h78
`define CBF_IDX_GOUT    8'h79
`define CBF_IDX_GPU     8'h7A
`define CBF_IDX_GPD     8'h7B
`define CBF_IDX_GFEN    8'h7C
`define CBF_IDX_GIN     8'h7D
// field positions
`define CBF_BCFG_KEEP   7
`define CBF_DCFG_NLAT   0
`define CBF_TCFG_SQZ    0
`define CBF_DFLT_CKS    0
`define CBF_SHDN_DIG    0
`define CBF_SHDN_APD    1
`define CBF_SHDN_ATSD   2
`define CBF_EV_CKS      0
`define CBF_EV_PIN      1
`define CBF_EV_TMR      2
`define CBF_EV_SHDN     3
`define CBF_EV_STOP     4
// reset values
`define CBF_RST_MASK    16'h0000
`define CBF_RST_DUR     4'h0
// timing: one balance duration unit
`define CBF_UNIT_MS     1000
`define CBF_CLK_MHZ     250
`define CBF_TICK_CYCLES (`CBF_UNIT_MS * 1000 * `CBF_CLK_MHZ)
`endif

// File: pkg/cbf_pkg.sv
// types of the cell balance and fault control block
package cbf_pkg;
	typedef enum logic [1:0] {
		CBF_RUN  = 2'b00,
		CBF_SHDN = 2'b01
	} cbf_mode_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdat;
		logic [15:0] mask;
		logic        keep;
		logic [3:0]  dur;
		logic        nlat;
		logic        sqz;
		logic        cks;
		logic [5:0]  dir;
		logic [5:0]  pout;
		logic [5:0]  pu;
		logic [5:0]  pd;
		logic [5:0]  fen;
		logic [5:0]  gflt;
		logic [5:0]  p1;
		logic [5:0]  p2;
		logic [5:0]  p3;
		logic [5:0]  pin;
		logic [1:0]  t1;
		logic [1:0]  t2;
		logic [1:0]  t3;
		logic [1:0]  thermal_trip_sensor;
		logic        w1;
		logic        w2;
		logic        w3;
		logic        wake;
		cbf_mode_t   mode;
		logic [2:0]  shdn;
		logic [4:0]  ist;
		logic [4:0]  imask;
		logic [27:0] pre;
		logic [3:0]  units;
		logic        bal_pwr;
	} cbf_state_t;
endpackage : cbf_pkg

// File: logic/cbf_cell_balance.sv
// cell balance drive, pin fault, thermal shutdown and wishbone registers
`timescale 1ns/1ps
`include "cbf_defs.svh"

// Contract
// R1 - sixteen drive outputs, each on while its balance mask bit is set
// R2 - cleared mask bit turns its drive output off
// R3 - host keeps open-wire squeeze disabled while balancing
// R4 - keep option at zero: any fault clears the whole balance mask
// R5 - user checksum fault never clears the balance mask
// R6 - after fault stop mask stays zero until faults cleared; duration kept
// R7 - host rewrites the mask to resume after a fault stop
// R8 - keep option at one: faults leave mask and config untouched
// R9 - every mask change sets the user checksum error flag
// R10 - balancing timer expiry clears the mask
// R11 - balancing circuitry powered only while any mask bit set
// R12 - six pins, each programmable as input or output
// R13 - each pin has selectable pull-up and pull-down
// R14 - pin raises fault only when its fault enable bit is set
// R15 - pin fault latches unless non-latching fault bit is set
// R16 - either thermal sensor enters shutdown; no exit while hot
// R17 - on wake, digital or analog thermal shutdown status bits are set; code sets them on shutdown entry instead
// R18 - balance fault is OR of all sources except checksum, each cycle
module cbf_cell_balance
	import cbf_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `CBF_TICK_CYCLES
) (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [11:0] i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	input  wire logic        i_ext_fault,
	input  wire logic [5:0]  i_pin_in,
	output logic      [5:0]  o_pin_out,
	output logic      [5:0]  o_pin_oe,
	output logic      [5:0]  o_pin_pull_up,
	output logic      [5:0]  o_pin_pull_down,
	input  wire logic        i_tsd_digital,
	input  wire logic        i_tsd_analog,
	input  wire logic        i_wakeup,
	output logic             o_shutdown,
	output logic      [15:0] o_balance_drive,
	output logic             o_balance_power,
	output logic             o_irq
);

	// ==========================================================
	// helpers
	// ==========================================================
	function automatic logic [15:0] lanes(
		input logic [15:0] old,
		input logic [31:0] dat,
		input logic [3:0]  sel
	);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			r[15:8] = dat[15:8];
		end
		return r;
	endfunction : lanes

	function automatic logic [5:0] w1c6(
		input logic [5:0] cur,
		input logic [5:0] set,
		input logic [5:0] clr
	);
		// set wins over a clear in the same cycle
		return (cur & ~clr) | set;
	endfunction : w1c6

	localparam logic [27:0] TICK_LAST = 28'(TICK_CYCLES - 1);

	cbf_state_t s;
	cbf_state_t next_s;

	logic        req;
	logic        wr;
	logic        rd;
	logic [7:0]  idx;
	logic [15:0] wv;
	logic [5:0]  pin_raw;
	logic [5:0]  gclr;
	logic        fault;
	logic        stop;
	logic        expire;
	logic        hot;
	logic [4:0]  ev;
	logic [15:0] mask_new;
	logic [31:0] rv;
	logic [2:0]  shdn_set;

	// ==========================================================
	// next state
	// ==========================================================
	always_comb begin
		next_s   = s;
		req      = i_wb_cyc & i_wb_stb & ~s.ack;
		wr       = req & i_wb_we;
		rd       = req & ~i_wb_we;
		idx      = i_wb_adr[9:2];
		wv       = 16'h0000;
		gclr     = 6'h00;
		ev       = 5'h00;
		expire   = 1'b0;
		mask_new = s.mask;
		rv       = 32'h0000_0000;
		shdn_set = 3'h0;

		// pin and thermal synchronisers; filtered on 2nd/3rd agree
		next_s.p1 = i_pin_in;
		next_s.p2 = s.p1;
		next_s.p3 = s.p2;
		for (int i = 0; i < 6; i++) begin
			if (s.p2[i] == s.p3[i]) begin
				next_s.pin[i] = s.p3[i];
			end
		end
		next_s.t1 = {i_tsd_analog, i_tsd_digital};
		next_s.t2 = s.t1;
		next_s.t3 = s.t2;
		for (int i = 0; i < 2; i++) begin
			if (s.t2[i] == s.t3[i]) begin
				next_s.thermal_trip_sensor[i] = s.t3[i];
			end
		end
		next_s.w1 = i_wakeup;
		next_s.w2 = s.w1;
		next_s.w3 = s.w2;
		if (s.w2 == s.w3) begin
			next_s.wake = s.w3;
		end

		// ======================================================
		// pin faults
		// ======================================================
		pin_raw = s.pin & s.fen; // R14
		if (wr && idx == `CBF_IDX_GFLT && i_wb_sel[0]) begin
			gclr = i_wb_dat[5:0];
		end
		// live copy when non-latching, else sticky
		if (s.nlat) begin // R15
			next_s.gflt = pin_raw;
		end else begin
			next_s.gflt = w1c6(s.gflt, pin_raw, gclr); // R15
		end
		if (|(pin_raw & ~s.gflt)) begin
			ev[`CBF_EV_PIN] = 1'b1;
		end

		// ======================================================
		// thermal shutdown
		// ======================================================
		hot = |s.thermal_trip_sensor;
		unique case (s.mode)
			CBF_RUN: begin
				if (hot) begin // R16
					next_s.mode = CBF_SHDN;
					ev[`CBF_EV_SHDN] = 1'b1;
					if (s.thermal_trip_sensor[0]) begin
						shdn_set[`CBF_SHDN_DIG] = 1'b1; // R17
					end
					if (s.thermal_trip_sensor[1]) begin
						shdn_set[`CBF_SHDN_APD]  = 1'b1; // R17
						shdn_set[`CBF_SHDN_ATSD] = 1'b1; // R17
					end
				end
			end
			CBF_SHDN: begin
				// no self exit; wake refused while still hot
				if (s.wake && !hot) begin // R16
					next_s.mode = CBF_RUN;
				end
			end
			default: begin
				next_s.mode = CBF_SHDN;
			end
		endcase

		// ======================================================
		// balancing
		// ======================================================
		// checksum flag is not a source, so it never stops balancing
		fault = i_ext_fault | (|s.gflt) | (s.mode != CBF_RUN); // R18 R5
		stop  = fault & ~s.keep; // R4 R8

		if (s.mask != 16'h0000 && s.dur != 4'h0) begin
			if (s.pre == TICK_LAST) begin
				next_s.pre   = 28'h0000000;
				next_s.units = s.units + 4'h1;
				if (s.units + 4'h1 == s.dur) begin
					expire = 1'b1;
				end
			end else begin
				next_s.pre = s.pre + 28'h0000001;
			end
		end else begin
			next_s.pre   = 28'h0000000;
			next_s.units = 4'h0;
		end

		if (wr && idx == `CBF_IDX_MASK) begin
			mask_new = lanes(s.mask, i_wb_dat, i_wb_sel);
		end
		if (expire) begin
			mask_new = 16'h0000; // R10
			ev[`CBF_EV_TMR] = 1'b1;
		end
		// writes are dropped while the stop holds
		if (stop) begin
			mask_new = 16'h0000; // R4 R6
		end
		if (stop && s.mask != 16'h0000) begin
			ev[`CBF_EV_STOP] = 1'b1;
		end
		next_s.mask = mask_new;
		if (mask_new != s.mask) begin
			next_s.pre   = 28'h0000000;
			next_s.units = 4'h0;
		end
		next_s.bal_pwr = |mask_new; // R11

		// checksum error flag: set wins over write-one clear
		if (wr && idx == `CBF_IDX_DFLT && i_wb_sel[0]
			&& i_wb_dat[`CBF_DFLT_CKS]) begin
			next_s.cks = 1'b0;
		end
		if (mask_new != s.mask) begin
			next_s.cks = 1'b1; // R9
			ev[`CBF_EV_CKS] = 1'b1;
		end

		// ======================================================
		// register writes
		// ======================================================
		if (wr) begin
			unique case (idx)
				`CBF_IDX_BCFG: begin
					// duration survives a fault stop
					wv = lanes({8'h00, s.keep, 3'h0, s.dur},
						i_wb_dat, i_wb_sel);
					next_s.keep = wv[`CBF_BCFG_KEEP];
					next_s.dur  = wv[3:0];
				end
				`CBF_IDX_DCFG: begin
					if (i_wb_sel[0]) begin
						next_s.nlat = i_wb_dat[`CBF_DCFG_NLAT];
					end
				end
				`CBF_IDX_TCFG: begin
					if (i_wb_sel[0]) begin
						next_s.sqz = i_wb_dat[`CBF_TCFG_SQZ];
					end
				end
				`CBF_IDX_SHDN: begin
					if (i_wb_sel[0]) begin
						next_s.shdn = s.shdn & ~i_wb_dat[2:0];
					end
				end
				`CBF_IDX_IMASK: begin
					if (i_wb_sel[0]) begin
						next_s.imask = i_wb_dat[4:0];
					end
				end
				`CBF_IDX_GDIR: begin
					if (i_wb_sel[0]) begin
						next_s.dir = i_wb_dat[5:0]; // R12
					end
				end
				`CBF_IDX_GOUT: begin
					if (i_wb_sel[0]) begin
						next_s.pout = i_wb_dat[5:0];
					end
				end
				`CBF_IDX_GPU: begin
					if (i_wb_sel[0]) begin
						next_s.pu = i_wb_dat[5:0]; // R13
					end
				end
				`CBF_IDX_GPD: begin
					if (i_wb_sel[0]) begin
						next_s.pd = i_wb_dat[5:0]; // R13
					end
				end
				`CBF_IDX_GFEN: begin
					if (i_wb_sel[0]) begin
						next_s.fen = i_wb_dat[5:0]; // R14
					end
				end
				default: begin
				end
			endcase
		end
		// a shutdown entry in the same cycle keeps its status bits
		next_s.shdn = next_s.shdn | shdn_set; // R17

		// ======================================================
		// reads
		// ======================================================
		unique case (idx)
			`CBF_IDX_MASK:  rv = {16'h0000, s.mask};
			`CBF_IDX_BCFG:  rv = {24'h000000, s.keep, 3'h0, s.dur};
			`CBF_IDX_DCFG:  rv = {31'h00000000, s.nlat};
			`CBF_IDX_TCFG:  rv = {31'h00000000, s.sqz};
			`CBF_IDX_DFLT:  rv = {31'h00000000, s.cks};
			`CBF_IDX_GFLT:  rv = {26'h0000000, s.gflt};
			`CBF_IDX_SHDN:  rv = {29'h00000000, s.shdn};
			`CBF_IDX_ISTAT: rv = {27'h0000000, s.ist};
			`CBF_IDX_IMASK: rv = {27'h0000000, s.imask};
			`CBF_IDX_GDIR:  rv = {26'h0000000, s.dir};
			`CBF_IDX_GOUT:  rv = {26'h0000000, s.pout};
			`CBF_IDX_GPU:   rv = {26'h0000000, s.pu};
			`CBF_IDX_GPD:   rv = {26'h0000000, s.pd};
			`CBF_IDX_GFEN:  rv = {26'h0000000, s.fen};
			`CBF_IDX_GIN:   rv = {26'h0000000, s.pin};
			default:        rv = 32'h0000_0000;
		endcase

		// interrupt status: read clears, new events win
		if (rd && idx == `CBF_IDX_ISTAT) begin
			next_s.ist = ev;
		end else begin
			next_s.ist = s.ist | ev;
		end

		// bus answer one cycle after the request, for one cycle
		next_s.ack  = req;
		next_s.rdat = rd ? rv : 32'h0000_0000;
	end

	// ==========================================================
	// state register
	// ==========================================================
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s       <= '0;
			s.mask  <= `CBF_RST_MASK;
			s.dur   <= `CBF_RST_DUR;
			s.mode  <= CBF_RUN;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	// ==========================================================
	assign o_wb_ack        = s.ack;
	assign o_wb_dat        = s.rdat;
	assign o_balance_drive = s.mask;    // R1 R2
	assign o_balance_power = s.bal_pwr; // R11
	assign o_pin_out       = s.pout;
	assign o_pin_oe        = s.dir;     // R12
	assign o_pin_pull_up   = s.pu;      // R13
	assign o_pin_pull_down = s.pd;      // R13
	assign o_shutdown      = (s.mode != CBF_RUN);
	assign o_irq           = |(s.ist & s.imask);

endmodule : cbf_cell_balance

// File: verif/cbf_cell_balance_monitor.sv
// concurrent checks on the cell balance block ports
`timescale 1ns/1ps
`include "cbf_defs.svh"
module cbf_mon #(
	parameter int unsigned TICK_CYCLES = 10
) (
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [11:0] i_wb_adr,
	input wire logic [3:0]  i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic        i_ext_fault,
	input wire logic        i_tsd_digital,
	input wire logic        i_tsd_analog,
	input wire logic        o_shutdown,
	input wire logic [15:0] o_balance_drive,
	input wire logic        o_balance_power
);
	// ==========================================
	// keep option shadowed from bus writes
	logic keep;
	logic wr;
	assign wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
	always_ff @(posedge i_clk) begin
		if (i_reset)
			keep <= 1'b0;
		else if (wr && i_wb_adr[9:2] == `CBF_IDX_BCFG && i_wb_sel[0])
			keep <= i_wb_dat[`CBF_BCFG_KEEP];
	end
	// ==========================================
	// assertions
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	a_ack_next:
	assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("ack missing after request");
	a_ack_drop:
	assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_power_tie:
	assert property (o_balance_power == (|o_balance_drive))
		else $error("balance power not tied to drive");
	a_fault_clear:
	assert property (i_ext_fault && !keep |=> o_balance_drive == 16'h0000)
		else $error("fault did not clear drive");
	a_mask_write:
	assert property (keep && wr && i_wb_adr[9:2] == `CBF_IDX_MASK &&
		i_wb_sel[1:0] == 2'b11 |-> o_balance_drive == i_wb_dat[15:0])
		else $error("drive differs from written mask");
	a_dig_trip:
	assert property ($rose(i_tsd_digital) |-> ##[1:6] o_shutdown)
		else $error("digital trip without shutdown");
	a_ana_trip:
	assert property ($rose(i_tsd_analog) |-> ##[1:6] o_shutdown)
		else $error("analog trip without shutdown");
	a_shdn_hold:
	assert property (o_shutdown && (i_tsd_digital || i_tsd_analog)
		|=> o_shutdown)
		else $error("left shutdown while hot");
	c_fault: cover property (i_ext_fault && !keep ##1 !o_balance_power);
	c_shdn: cover property ($rose(o_shutdown));
	c_bal: cover property (o_balance_power ##1 !o_balance_power);
endmodule : cbf_mon

// File: verif/cbf_fet.sv
// external balancing transistor bank, one per cell
`timescale 1ns/1ps
module cbf_fet (
	input  wire logic [15:0] i_drive,
	output logic      [15:0] o_current
);
	// gate high pulls current, gate low stops it at once
	assign o_current = i_drive;
endmodule : cbf_fet

// File: verif/tb_cbf_cell_balance.sv
// testbench for the cell balance and fault control block
`timescale 1ns/1ps
`include "cbf_defs.svh"
module tb_cbf_cell_balance;
	import cbf_pkg::*;
	localparam int unsigned TICK_CYCLES = 10;
	logic i_clk = 0, i_reset = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
	logic [11:0] i_wb_adr = 0;
	logic [3:0] i_wb_sel = 0;
	logic [31:0] i_wb_dat = 0, o_wb_dat, q;
	logic o_wb_ack, o_shutdown, o_balance_power, o_irq;
	logic i_ext_fault = 0, i_tsd_digital = 0, i_tsd_analog = 0, i_wakeup = 0;
	logic [5:0] i_pin_in = 0, o_pin_out, o_pin_oe;
	logic [5:0] o_pin_pull_up, o_pin_pull_down;
	logic [15:0] o_balance_drive, cur;
	int mismatches = 0, total_checks = 0;
	cbf_cell_balance #(.TICK_CYCLES(TICK_CYCLES)) cbf_cell_balance_i (.*);
	cbf_fet cbf_fet_i (.i_drive(o_balance_drive), .o_current(cur));
	initial begin
		forever #2 i_clk = ~i_clk;
	end
	// ==========================================
	// bus and compare tasks
	task automatic wb(input logic w, input logic [7:0] x, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_sel} <= {3'b110 | w, 4'hF};
		i_wb_adr <= {2'b00, x, 2'b00};
		i_wb_dat <= {16'h0000, d};
		do begin
			@(posedge i_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			$display("BAD ack expected 1 seen 0");
		end
		q = o_wb_dat;
		{i_wb_cyc, i_wb_stb, i_wb_we} <= 3'b000;
	endtask : wb
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] x, input logic [31:0] e, input string s);
		wb(0, x, 0);
		chk(s, e, q);
	endtask : rdc
	task automatic pause(input int n);
		repeat (n) @(posedge i_clk);
	endtask : pause
	task automatic therm(input logic a, input logic [31:0] e);
		pause(1);
		if (a) i_tsd_analog <= 1; else i_tsd_digital <= 1;
		pause(8);
		chk("shutdown", 1, o_shutdown);
		i_wakeup <= 1;
		pause(8);
		chk("hot wake", 1, o_shutdown);
		{i_tsd_analog, i_tsd_digital} <= 2'b00;
		pause(8);
		chk("woken", 0, o_shutdown);
		i_wakeup <= 0;
		rdc(`CBF_IDX_SHDN, e, "shdn status");
		wb(1, `CBF_IDX_SHDN, 16'h0007);
	endtask : therm
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	// ==========================================
	// tests; timer runs at TICK_CYCLES per unit
	initial begin
		pause(10);
		i_reset <= 0;
		rdc(`CBF_IDX_MASK, 0, "mask reset");
		wb(1, `CBF_IDX_TCFG, 16'h0000);
		wb(1, `CBF_IDX_IMASK, 16'h001F);
		for (int n = 0; n < 16; n++) begin
			wb(1, `CBF_IDX_MASK, 16'h0001 << n);
			#1 chk("drive", 16'h0001 << n, o_balance_drive);
			chk("fet", 16'h0001 << n, cur);
		end
		wb(1, `CBF_IDX_MASK, 16'h0000);
		#1 chk("drive off", 0, o_balance_drive);
		chk("power off", 0, o_balance_power);
		rdc(`CBF_IDX_DFLT, 1, "cks flag");
		chk("irq on", 1, o_irq);
		rdc(`CBF_IDX_ISTAT, 1, "istat");
		#1 chk("irq off", 0, o_irq);
		$display("test mask done");
		wb(1, `CBF_IDX_DFLT, 16'h0001);
		wb(1, `CBF_IDX_MASK, 16'h00F0);
		pause(4);
		chk("cks keeps", 16'h00F0, o_balance_drive);
		rdc(`CBF_IDX_DFLT, 1, "cks again");
		wb(1, `CBF_IDX_BCFG, 16'h0005);
		wb(1, `CBF_IDX_DFLT, 16'h0001);
		i_ext_fault <= 1;
		pause(3);
		chk("fault stop", 0, o_balance_drive);
		wb(1, `CBF_IDX_MASK, 16'h000F);
		rdc(`CBF_IDX_MASK, 0, "mask held");
		rdc(`CBF_IDX_BCFG, 5, "dur kept");
		rdc(`CBF_IDX_DFLT, 1, "cks on stop");
		i_ext_fault <= 0;
		wb(1, `CBF_IDX_DFLT, 16'h0001);
		rdc(`CBF_IDX_ISTAT, 32'h11, "stop event");
		wb(1, `CBF_IDX_MASK, 16'h000F);
		#1 chk("resume", 16'h000F, o_balance_drive);
		wb(1, `CBF_IDX_BCFG, 16'h0080);
		i_ext_fault <= 1;
		pause(3);
		chk("keep on", 16'h000F, o_balance_drive);
		wb(1, `CBF_IDX_MASK, 16'h00FF);
		#1 chk("keep write", 16'h00FF, o_balance_drive);
		rdc(`CBF_IDX_BCFG, 16'h0080, "cfg kept");
		i_ext_fault <= 0;
		$display("test fault done");
		wb(1, `CBF_IDX_BCFG, 16'h0002);
		wb(0, `CBF_IDX_ISTAT, 0);
		wb(1, `CBF_IDX_MASK, 16'h0001);
		pause(2 * TICK_CYCLES + 10);
		chk("expired", 0, o_balance_drive);
		wb(0, `CBF_IDX_ISTAT, 0);
		chk("tmr event", 1, q[`CBF_EV_TMR]);
		wb(1, `CBF_IDX_BCFG, 16'h0000);
		$display("test timer done");
		wb(1, `CBF_IDX_GDIR, 16'h002A);
		wb(1, `CBF_IDX_GOUT, 16'h0015);
		wb(1, `CBF_IDX_GPU, 16'h000F);
		wb(1, `CBF_IDX_GPD, 16'h0030);
		#1 chk("oe", 6'h2A, o_pin_oe);
		chk("out", 6'h15, o_pin_out);
		chk("pu", 6'h0F, o_pin_pull_up);
		chk("pd", 6'h30, o_pin_pull_down);
		i_pin_in <= 6'h2D;
		pause(6);
		rdc(`CBF_IDX_GIN, 6'h2D, "pin in");
		i_pin_in <= 6'h01;
		wb(1, `CBF_IDX_MASK, 16'h0003);
		pause(6);
		rdc(`CBF_IDX_GFLT, 0, "no pin fault");
		chk("no stop", 16'h0003, o_balance_drive);
		wb(1, `CBF_IDX_GFEN, 16'h0001);
		pause(6);
		rdc(`CBF_IDX_GFLT, 1, "pin fault");
		chk("pin stop", 0, o_balance_drive);
		i_pin_in <= 6'h00;
		pause(6);
		rdc(`CBF_IDX_GFLT, 1, "latched");
		wb(1, `CBF_IDX_GFLT, 16'h0001);
		rdc(`CBF_IDX_GFLT, 0, "cleared");
		wb(1, `CBF_IDX_DCFG, 16'h0001);
		i_pin_in <= 6'h01;
		pause(6);
		rdc(`CBF_IDX_GFLT, 1, "live on");
		i_pin_in <= 6'h00;
		pause(6);
		rdc(`CBF_IDX_GFLT, 0, "live off");
		wb(1, `CBF_IDX_GFEN, 16'h0000);
		$display("test pins done");
		therm(0, 32'h1);
		therm(1, 32'h6);
		$display("test thermal done");
		final_report;
	end
	initial begin
		pause(20000);
		mismatches++;
		$display("watchdog expired");
		final_report;
	end
endmodule : tb_cbf_cell_balance
bind cbf_cell_balance cbf_mon #(.TICK_CYCLES(TICK_CYCLES)) cbf_mon_i (.*);
